// [design/interrupt_unit_pkg.sv]
// Constants and types shared by the cascaded interrupt unit.
package interrupt_unit_pkg;

  localparam int ADDR_W = 8;
  localparam int CFG_W  = 13;

  localparam logic [7:0] OFF_CFG_M  = 8'h00;
  localparam logic [7:0] OFF_CFG_S  = 8'h04;
  localparam logic [7:0] OFF_MASK_M = 8'h08;
  localparam logic [7:0] OFF_MASK_S = 8'h0c;
  localparam logic [7:0] OFF_CMD    = 8'h10;
  localparam logic [7:0] OFF_STAT_M = 8'h14;
  localparam logic [7:0] OFF_STAT_S = 8'h18;
  localparam logic [7:0] OFF_PINCFG = 8'h1c;
  localparam logic [7:0] OFF_CASC   = 8'h20;

  localparam int CFG_BASE_LSB = 3;
  localparam int CFG_LEVEL    = 8;
  localparam int CFG_SFNM     = 9;
  localparam int CFG_AUTO_END_OF_SERVICE     = 10;
  localparam int CFG_AUTOROT  = 11;
  localparam int CFG_SMM      = 12;

  localparam int PIN_P3_LSB   = 0;
  localparam int PIN_UP4      = 4;
  localparam int PIN_UP5_SEL  = 5;
  localparam int PIN_UP6      = 6;
  localparam int PIN_UP7      = 7;
  localparam int PIN_CAS_ADDR = 8;

  localparam int CMD_LINE_LSB = 0;
  localparam int CMD_SLAVE    = 3;
  localparam int CMD_OP_LSB   = 4;

  localparam logic [CFG_W-1:0] CFG_RST    = 13'h0000;
  localparam logic [7:0]       MASK_RST   = 8'hff;
  localparam logic [8:0]       PINCFG_RST = 9'h000;
  localparam logic [7:0]       CASC_RST   = 8'h00;
  localparam logic [7:0]       EXT_LINES  = 8'he2;
  localparam logic [2:0]       LOWEST_RST = 3'h7;
  localparam logic [2:0]       DEFAULT_LN = 3'h7;
  localparam logic [2:0]       SLAVE_LINE = 3'h2;

  typedef enum logic [1:0] {
    OP_NONE        = 2'h0,
    OP_EOI_NONSPEC = 2'h1,
    OP_EOI_SPEC    = 2'h2,
    OP_SET_LOWEST  = 2'h3
  } cmd_op_t;

  typedef enum logic [1:0] {
    ACK_IDLE   = 2'h0,
    ACK_FIRST  = 2'h1,
    ACK_GAP    = 2'h3,
    ACK_SECOND = 2'h2
  } ack_state_t;

endpackage

// [design/resolve_if.sv]
// Carrier between a controller's state and its priority resolver.
`timescale 1ns/1ps
interface resolve_if;
  logic [7:0] req;
  logic [7:0] isr;
  logic [2:0] lowest;
  logic       sfnm;
  logic       smm;
  logic       grant_valid;
  logic [2:0] grant_line;
  logic       top_isr_valid;
  logic [2:0] top_isr_line;
  modport ctl (output req, isr, lowest, sfnm, smm,
               input grant_valid, grant_line, top_isr_valid, top_isr_line);
  modport res (input req, isr, lowest, sfnm, smm,
               output grant_valid, grant_line, top_isr_valid, top_isr_line);
endinterface

// [design/pin_sync.sv]
// Two-stage synchroniser for the external request pins.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t st_reg;
  sync_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.s2;
endmodule

// [design/interrupt_resolver.sv]
// Rotating priority resolver for one eight-line controller.
`timescale 1ns/1ps
module interrupt_resolver (
  resolve_if.res bus
);
  logic       stop;
  logic       ifound;
  logic [2:0] ln;

  // Scans from the highest level downwards; outside special mask mode an in-service level blocks lower ones.
  always_comb begin
    stop                 = 1'b0;
    ifound               = 1'b0;
    ln                   = 3'h0;
    bus.grant_valid      = 1'b0;
    bus.grant_line       = 3'h0;
    bus.top_isr_valid    = 1'b0;
    bus.top_isr_line     = 3'h0;
    for (int k = 0; k < 8; k++) begin
      ln = 3'(bus.lowest + 3'(k) + 3'h1); // see R12, R13
      if (!ifound && bus.isr[ln]) begin
        ifound           = 1'b1;
        bus.top_isr_valid = 1'b1;
        bus.top_isr_line = ln;
      end
      if (!stop) begin
        if (!bus.sfnm && !bus.smm && bus.isr[ln]) begin
          stop = 1'b1; // see R15, R16
        end else if (bus.req[ln]) begin
          stop           = 1'b1;
          bus.grant_valid = 1'b1; // see R2
          bus.grant_line = ln;
        end else if (!bus.smm && bus.isr[ln]) begin
          stop = 1'b1; // see R17
        end
      end
    end
  end
endmodule

// [design/interrupt_unit.sv]
// Cascaded master and slave interrupt controller with APB registers.
// How it works
// R1: Sixteen sources, eight internal and eight pins, feed master and slave controllers.
// R2: Master raises the CPU request only for unmasked lines of enough priority.
// R3: Slave request output drives master request line 2.
// R4: Two acknowledge pulses; the granted controller drives its vector on the second.
// R5: Master drives cascade select, optionally mirrored onto the upper address pins.
// R6: External slaves decode their own strobes and answer only when selected.
// R7: A port-function shared pin feeds a grounded request input.
// R8: Pin 5 and sync serial share slave line 1, one selected.
// R9: Master lines: timer0, pin0, slave, serial1, serial0, pins 1 to 3.
// R10: Slave lines: pin4, pin5/sync serial, timers 1, 2, DMA, pins 6, 7, watchdog.
// R11: Edge mode recognises a low-to-high transition as a request.
// R12: After reset line 0 ranks highest and line 7 lowest.
// R13: Specific rotation makes the named line lowest, the next one highest.
// R14: Auto rotation makes a serviced line lowest.
// R15: Fully nested mode lets only strictly higher levels preempt.
// R16: Fully nested master holds a new line 2 request while line 2 serves.
// R17: Special fully nested mode lets equal or higher levels preempt.
// R18: Special mask mode switches at run time, masking only in-service lines.
// R19: Each line has its own mask bit.
// R20: Acknowledge sets the granted in-service bit and, in edge mode, clears its pending bit.
// R21: Vector is base, aligned to eight, plus line number.
// R22: In-service clears by auto end (master only), specific or nonspecific command.
// R23: Level mode keeps a high line as a live request.
// R24: No live request at acknowledge yields the line-7 default vector.
`timescale 1ns/1ps
module interrupt_unit
  import interrupt_unit_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        external_request_pins,
  input  wire logic              timer0_output,
  input  wire logic              timer1_output,
  input  wire logic              timer2_output,
  input  wire logic              async_serial0_event,
  input  wire logic              async_serial1_event,
  input  wire logic              sync_serial_event,
  input  wire logic              dma_event,
  input  wire logic              watchdog_expiry_n,
  input  wire logic              acknowledge_strobe_n,
  output logic                   cpu_request,
  output logic      [7:0]        vector_out,
  output logic                   vector_valid,
  output logic      [2:0]        cascade_select,
  output logic      [2:0]        cascade_addr_out,
  output logic                   cascade_addr_en
);

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [7:0]       imr;
    logic [7:0]       irr;
    logic [7:0]       isr;
    logic [7:0]       prev;
    logic [2:0]       lowest;
  } ctl_t;

  typedef struct packed {
    ctl_t [1:0]  ctl;
    logic [8:0]  pincfg;
    logic [7:0]  casc;
    ack_state_t  ack;
    logic        ack_prev;
    logic        m_valid;
    logic [2:0]  m_line;
    logic        ext_resp;
    logic [2:0]  cas;
    logic        cas_en;
    logic [7:0]  vec;
    logic        vec_drive;
    logic        intr;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [7:0]       pins;
  logic [1:0]       gnt_v;
  logic [1:0][2:0]  gnt_l;
  logic [1:0]       top_v;
  logic [1:0][2:0]  top_l;
  logic [1:0][7:0]  raw;
  logic [1:0][7:0]  set_isr;
  logic [1:0][7:0]  clr_isr;
  logic [1:0][7:0]  clr_irr;
  logic [1:0][7:0]  rise;
  logic             fall_ack;
  logic             rise_ack;
  logic             wr_en;
  logic             rd_cap;
  logic [2:0]       cmd_line;
  logic             cmd_c;
  cmd_op_t          cmd_op;
  logic [31:0]      rd_val;
  logic             rd_err;

  pin_sync #(.W(8)) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (external_request_pins),
    .dout    (pins)
  );

  for (genvar c = 0; c < 2; c++) begin : g_ctl
    resolve_if ri ();
    // In special mask mode the in-service line itself is masked out.
    assign ri.req    = st_reg.ctl[c].irr & ~st_reg.ctl[c].imr
                       & (st_reg.ctl[c].cfg[CFG_SMM] ? ~st_reg.ctl[c].isr : 8'hff); // see R18, R19
    assign ri.isr    = st_reg.ctl[c].isr;
    assign ri.lowest = st_reg.ctl[c].lowest;
    assign ri.sfnm   = st_reg.ctl[c].cfg[CFG_SFNM]; // see R17
    assign ri.smm    = st_reg.ctl[c].cfg[CFG_SMM];  // see R18
    assign gnt_v[c]  = ri.grant_valid;
    assign gnt_l[c]  = ri.grant_line;
    assign top_v[c]  = ri.top_isr_valid;
    assign top_l[c]  = ri.top_isr_line;
    interrupt_resolver u_res (
      .bus (ri.res)
    );
  end

  // Source routing; shared pins not in interrupt function read as ground, except pin 5, whose line then takes sync serial.
  always_comb begin
    raw[0][0] = timer0_output; // see R9
    raw[0][1] = pins[0] & st_reg.pincfg[PIN_P3_LSB];     // see R7
    raw[0][2] = gnt_v[1];                                 // see R3
    raw[0][3] = async_serial1_event;
    raw[0][4] = async_serial0_event;
    raw[0][5] = pins[1] & st_reg.pincfg[PIN_P3_LSB + 1];
    raw[0][6] = pins[2] & st_reg.pincfg[PIN_P3_LSB + 2];
    raw[0][7] = pins[3] & st_reg.pincfg[PIN_P3_LSB + 3];
    raw[1][0] = pins[4] & st_reg.pincfg[PIN_UP4];         // see R10
    raw[1][1] = st_reg.pincfg[PIN_UP5_SEL] ? pins[5] : sync_serial_event; // see R8
    raw[1][2] = timer1_output;
    raw[1][3] = timer2_output;
    raw[1][4] = dma_event;
    raw[1][5] = pins[6] & st_reg.pincfg[PIN_UP6];
    raw[1][6] = pins[7] & st_reg.pincfg[PIN_UP7];
    raw[1][7] = ~watchdog_expiry_n; // see R1
  end

  // Register read mux.
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      OFF_CFG_M:  rd_val = 32'(st_reg.ctl[0].cfg);
      OFF_CFG_S:  rd_val = 32'(st_reg.ctl[1].cfg);
      OFF_MASK_M: rd_val = 32'(st_reg.ctl[0].imr);
      OFF_MASK_S: rd_val = 32'(st_reg.ctl[1].imr);
      OFF_CMD:    rd_val = 32'h0000_0000;
      OFF_STAT_M: rd_val = 32'({st_reg.ctl[0].lowest, st_reg.ctl[0].isr, st_reg.ctl[0].irr});
      OFF_STAT_S: rd_val = 32'({st_reg.ctl[1].lowest, st_reg.ctl[1].isr, st_reg.ctl[1].irr});
      OFF_PINCFG: rd_val = 32'(st_reg.pincfg);
      OFF_CASC:   rd_val = 32'(st_reg.casc);
      default:    rd_err = 1'b1;
    endcase
  end

  assign wr_en    = psel & penable & st_reg.pready & pwrite;
  assign rd_cap   = psel & penable & ~st_reg.pready;
  assign cmd_line = pwdata[CMD_LINE_LSB +: 3];
  assign cmd_c    = pwdata[CMD_SLAVE];
  assign cmd_op   = cmd_op_t'(pwdata[CMD_OP_LSB +: 2]);
  assign fall_ack = st_reg.ack_prev & ~acknowledge_strobe_n;
  assign rise_ack = ~st_reg.ack_prev & acknowledge_strobe_n;

  always_comb begin
    st_next          = st_reg;
    set_isr          = '0;
    clr_isr          = '0;
    clr_irr          = '0;
    st_next.ack_prev = acknowledge_strobe_n;

    // Bus answer after one wait state.
    st_next.pready   = rd_cap;
    if (rd_cap) begin
      st_next.prdata  = pwrite ? 32'h0000_0000 : rd_val;
      st_next.pslverr = rd_err;
    end else begin
      st_next.pslverr = 1'b0;
    end

    // Acknowledge sequence.
    case (st_reg.ack)
      ACK_IDLE: begin
        if (fall_ack) begin
          st_next.ack      = ACK_FIRST;
          st_next.cas_en   = 1'b1;
          st_next.ext_resp = 1'b0;
          st_next.m_valid  = gnt_v[0];
          if (gnt_v[0]) begin
            st_next.m_line                = gnt_l[0];
            st_next.cas                   = gnt_l[0]; // see R5
            set_isr[0][gnt_l[0]]          = 1'b1; // see R20
            clr_irr[0][gnt_l[0]]          = 1'b1;
            st_next.vec = {st_reg.ctl[0].cfg[CFG_BASE_LSB +: 5], gnt_l[0]}; // see R21
            if (gnt_l[0] == SLAVE_LINE) begin
              if (gnt_v[1]) begin
                set_isr[1][gnt_l[1]] = 1'b1; // see R4, R20
                clr_irr[1][gnt_l[1]] = 1'b1;
                st_next.vec = {st_reg.ctl[1].cfg[CFG_BASE_LSB +: 5], gnt_l[1]};
              end else begin
                st_next.vec = {st_reg.ctl[1].cfg[CFG_BASE_LSB +: 5], DEFAULT_LN}; // see R24
              end
            end else if (st_reg.casc[gnt_l[0]] & EXT_LINES[gnt_l[0]]) begin
              st_next.ext_resp = 1'b1; // see R6
            end
          end else begin
            st_next.m_line = DEFAULT_LN;
            st_next.cas    = 3'h0;
            st_next.vec    = {st_reg.ctl[0].cfg[CFG_BASE_LSB +: 5], DEFAULT_LN}; // see R24
          end
        end
      end
      ACK_FIRST: begin
        if (rise_ack) begin
          st_next.ack = ACK_GAP;
        end
      end
      ACK_GAP: begin
        if (fall_ack) begin
          st_next.ack       = ACK_SECOND;
          st_next.vec_drive = ~st_reg.ext_resp; // see R4
        end
      end
      ACK_SECOND: begin
        if (rise_ack) begin
          st_next.ack       = ACK_IDLE;
          st_next.vec_drive = 1'b0;
          st_next.cas_en    = 1'b0;
          if (st_reg.ctl[0].cfg[CFG_AUTO_END_OF_SERVICE] && st_reg.m_valid) begin
            clr_isr[0][st_reg.m_line] = 1'b1; // see R22
            if (st_reg.ctl[0].cfg[CFG_AUTOROT]) begin
              st_next.ctl[0].lowest = st_reg.m_line; // see R14
            end
          end
        end
      end
      default: begin
        st_next.ack = ACK_IDLE;
      end
    endcase

    // Register writes and commands.
    if (wr_en) begin
      case (paddr)
        OFF_CFG_M:  st_next.ctl[0].cfg = pwdata[CFG_W-1:0];
        OFF_CFG_S:  st_next.ctl[1].cfg = pwdata[CFG_W-1:0] & ~(13'h0001 << CFG_AUTO_END_OF_SERVICE);
        OFF_MASK_M: st_next.ctl[0].imr = pwdata[7:0]; // see R19
        OFF_MASK_S: st_next.ctl[1].imr = pwdata[7:0];
        OFF_PINCFG: st_next.pincfg     = pwdata[8:0];
        OFF_CASC:   st_next.casc       = pwdata[7:0];
        OFF_CMD: begin
          case (cmd_op)
            OP_EOI_NONSPEC: begin
              if (top_v[cmd_c]) begin
                clr_isr[cmd_c][top_l[cmd_c]] = 1'b1; // see R22
                if (st_reg.ctl[cmd_c].cfg[CFG_AUTOROT]) begin
                  st_next.ctl[cmd_c].lowest = top_l[cmd_c]; // see R14
                end
              end
            end
            OP_EOI_SPEC: begin
              clr_isr[cmd_c][cmd_line] = 1'b1; // see R22
            end
            OP_SET_LOWEST: begin
              st_next.ctl[cmd_c].lowest = cmd_line; // see R13
            end
            default: begin
              st_next.ctl[cmd_c].lowest = st_reg.ctl[cmd_c].lowest;
            end
          endcase
        end
        default: begin
          st_next.casc = st_reg.casc;
        end
      endcase
    end

    // Pending and in-service update; a new event wins over a same-cycle clear.
    for (int c = 0; c < 2; c++) begin
      rise[c]             = raw[c] & ~st_reg.ctl[c].prev; // see R11
      st_next.ctl[c].prev = raw[c];
      if (st_reg.ctl[c].cfg[CFG_LEVEL]) begin
        st_next.ctl[c].irr = raw[c]; // see R23
      end else begin
        st_next.ctl[c].irr = (st_reg.ctl[c].irr & ~clr_irr[c]) | rise[c]; // see R11, R20
      end
      st_next.ctl[c].isr = (st_reg.ctl[c].isr & ~clr_isr[c]) | set_isr[c]; // see R20
    end

    st_next.intr = gnt_v[0]; // see R2
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{
        ctl: '{default: '{cfg: CFG_RST, imr: MASK_RST, irr: 8'h00, isr: 8'h00,
                          prev: 8'h00, lowest: LOWEST_RST}}, // see R12
        pincfg: PINCFG_RST,
        casc: CASC_RST,
        ack: ACK_IDLE,
        ack_prev: 1'b1,
        m_valid: 1'b0,
        m_line: 3'h0,
        ext_resp: 1'b0,
        cas: 3'h0,
        cas_en: 1'b0,
        vec: 8'h00,
        vec_drive: 1'b0,
        intr: 1'b0,
        prdata: 32'h0000_0000,
        pready: 1'b0,
        pslverr: 1'b0
      };
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata           = st_reg.prdata;
  assign pready           = st_reg.pready;
  assign pslverr          = st_reg.pslverr;
  assign cpu_request      = st_reg.intr;
  assign vector_out       = st_reg.vec;
  assign vector_valid     = st_reg.vec_drive;
  assign cascade_select   = st_reg.cas;
  assign cascade_addr_out = st_reg.cas;
  assign cascade_addr_en  = st_reg.cas_en & st_reg.pincfg[PIN_CAS_ADDR]; // see R5

endmodule

// [test/interrupt_unit_asserts.sv]
// Concurrent checks on the ports of the interrupt unit.
`timescale 1ns/1ps
module interrupt_unit_asserts (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       acknowledge_strobe_n,
  input wire logic       cpu_request,
  input wire logic [7:0] vector_out,
  input wire logic       vector_valid,
  input wire logic [2:0] cascade_select,
  input wire logic [2:0] cascade_addr_out,
  input wire logic       cascade_addr_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PREADY_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_SLVERR_PAIR: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an answer");
  AST_VALID_AFTER_FALL: assert property ($rose(vector_valid) |-> !$past(acknowledge_strobe_n))
    else $error("vector without a second pulse");
  AST_VALID_DROP: assert property (vector_valid && acknowledge_strobe_n |=> !vector_valid)
    else $error("vector held after the pulse");
  AST_CASC_MIRROR: assert property (cascade_addr_out == cascade_select)
    else $error("address pins differ from cascade select");
  AST_GRANT_AFTER_FALL: assert property ($rose(cascade_addr_en) |-> !$past(acknowledge_strobe_n))
    else $error("cascade enabled without a pulse");
  AST_SELECT_HELD: assert property (cascade_addr_en && $past(cascade_addr_en) |-> $stable(cascade_select))
    else $error("cascade select moved during the cycle");
  AST_VECTOR_LINE: assert property (vector_valid && cascade_select != 3'h0 && cascade_select != 3'h2
    |-> vector_out[2:0] == cascade_select)
    else $error("vector does not match the granted line");

  cover property (vector_valid && cascade_select == 3'h2);
  cover property (pslverr);
  cover property (cascade_addr_en && cpu_request);
endmodule

// [test/cpu_ack_model.sv]
// Behavioural CPU core that runs two-pulse acknowledge cycles.
`timescale 1ns/1ps
module cpu_ack_model (
  input  wire logic       pclk,
  input  wire logic       start,
  input  wire logic       slow,
  input  wire logic [7:0] vector_out,
  input  wire logic       vector_valid,
  output logic            acknowledge_strobe_n,
  output logic      [7:0] got_vector,
  output logic            done
);
  initial begin
    acknowledge_strobe_n = 1'h1;
    got_vector = 8'h00;
    done = 1'h0;
    forever begin
      @(posedge pclk);
      if (start === 1'h1) begin
        done <= 1'h0;
        got_vector <= 8'hxx;
        acknowledge_strobe_n <= 1'h0;
        @(posedge pclk);
        acknowledge_strobe_n <= 1'h1;
        repeat (slow ? 4 : 1) @(posedge pclk);
        acknowledge_strobe_n <= 1'h0;
        repeat (3) begin
          @(posedge pclk);
          if (vector_valid === 1'h1) got_vector <= vector_out;
        end
        acknowledge_strobe_n <= 1'h1;
        done <= 1'h1;
      end
    end
  end
endmodule

// [test/tb.sv]
// Self-checking bench for the cascaded interrupt unit.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) begin \
      mismatches++; \
      $display("wrong value %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb
  import interrupt_unit_pkg::*;
;
  typedef struct packed {logic [7:0] pins; logic [7:0] intl; logic [7:0] vec;} row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, external_request_pins, vector_out, v, got_vector;
  logic [31:0] pwdata, prdata, r;
  logic        timer0_output, timer1_output, timer2_output, async_serial0_event;
  logic        async_serial1_event, sync_serial_event, dma_event, watchdog_expiry_n;
  logic        acknowledge_strobe_n, cpu_request, vector_valid, cascade_addr_en;
  logic        start, slow, done;
  logic [2:0]  cascade_select, cascade_addr_out;
  int          mismatches, check_count;
  row_t        rows [15];

  interrupt_unit interrupt_unit_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .external_request_pins, .timer0_output,
    .timer1_output, .timer2_output, .async_serial0_event, .async_serial1_event,
    .sync_serial_event, .dma_event, .watchdog_expiry_n, .acknowledge_strobe_n,
    .cpu_request, .vector_out, .vector_valid, .cascade_select, .cascade_addr_out,
    .cascade_addr_en);
  cpu_ack_model cpu_ack_model_i (.pclk, .start, .slow, .vector_out, .vector_valid,
    .acknowledge_strobe_n, .got_vector, .done);

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) mismatches++;
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic end_of_service_cmd(input logic s);
    apb(1'h1, OFF_CMD, s ? 32'h0000_0018 : 32'h0000_0010);
  endtask

  task automatic src(input logic [7:0] p, input logic [7:0] s);
    external_request_pins <= p;
    {dma_event, sync_serial_event, async_serial1_event, async_serial0_event,
     timer2_output, timer1_output, timer0_output} <= s[6:0];
    watchdog_expiry_n <= ~s[7];
  endtask

  task automatic ack(output logic [7:0] vec);
    int n;
    n = 0;
    while (cpu_request !== 1'h1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    start <= 1'h1;
    @(posedge pclk);
    start <= 1'h0;
    @(posedge pclk);
    n = 0;
    while (done !== 1'h1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) mismatches++;
    vec = got_vector;
    @(posedge pclk);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    finish_test;
  end

  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, start, slow} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    src(8'h00, 8'h00);
    rows = '{'{8'h00, 8'h01, 8'h20}, '{8'h01, 8'h00, 8'h21}, '{8'h00, 8'h10, 8'h23},
             '{8'h00, 8'h08, 8'h24}, '{8'h02, 8'h00, 8'h25}, '{8'h04, 8'h00, 8'h26},
             '{8'h08, 8'h00, 8'h27}, '{8'h10, 8'h00, 8'h40}, '{8'h20, 8'h00, 8'h41},
             '{8'h00, 8'h02, 8'h42}, '{8'h00, 8'h04, 8'h43}, '{8'h00, 8'h40, 8'h44},
             '{8'h40, 8'h00, 8'h45}, '{8'h80, 8'h00, 8'h46}, '{8'h00, 8'h80, 8'h47}};
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, OFF_CFG_M, 32'h0000_0000);
    `CHK("cfg_m", 32'h0000_0000, r)
    apb(1'h0, OFF_MASK_S, 32'h0000_0000);
    `CHK("mask_s", 32'h0000_00ff, r)
    apb(1'h0, OFF_STAT_S, 32'h0000_0000);
    `CHK("stat_s", 32'h0007_0000, r)
    apb(1'h1, 8'h24, 32'h0000_0001);
    `CHK("unmapped", 1'h1, e)
    apb(1'h1, OFF_CFG_M, 32'h0000_0020);
    apb(1'h1, OFF_CFG_S, 32'h0000_0040);
    apb(1'h1, OFF_MASK_M, 32'h0000_0000);
    apb(1'h1, OFF_MASK_S, 32'h0000_0000);
    apb(1'h1, OFF_PINCFG, 32'h0000_01ff);
    foreach (rows[i]) begin
      slow <= i[0];
      src(rows[i].pins, rows[i].intl);
      ack(v);
      `CHK("vector", rows[i].vec, v)
      src(8'h00, 8'h00);
      if (rows[i].vec[6]) end_of_service_cmd(1'h1);
      end_of_service_cmd(1'h0);
      apb(1'h0, OFF_STAT_M, 32'h0000_0000);
      `CHK("stat_m", 32'h0007_0000, r)
    end
    apb(1'h1, OFF_MASK_M, 32'h0000_0001);
    src(8'h00, 8'h01);
    repeat (8) @(posedge pclk);
    `CHK("masked", 1'h0, cpu_request)
    apb(1'h1, OFF_MASK_M, 32'h0000_0000);
    ack(v);
    `CHK("unmasked", 8'h20, v)
    src(8'h00, 8'h00);
    end_of_service_cmd(1'h0);
    src(8'h00, 8'h09);
    ack(v);
    `CHK("first", 8'h20, v)
    repeat (8) @(posedge pclk);
    `CHK("nested", 1'h0, cpu_request)
    end_of_service_cmd(1'h0);
    ack(v);
    `CHK("second", 8'h24, v)
    src(8'h00, 8'h00);
    end_of_service_cmd(1'h0);
    for (int m = 0; m < 2; m++) begin
      apb(1'h1, OFF_CFG_M, m ? 32'h0000_0220 : 32'h0000_0020);
      src(8'h00, 8'h80);
      ack(v);
      src(8'h00, 8'h82);
      repeat (8) @(posedge pclk);
      `CHK("slave nest", m[0], cpu_request)
      end_of_service_cmd(1'h1);
      end_of_service_cmd(1'h0);
      ack(v);
      `CHK("slave vec", 8'h42, v)
      src(8'h00, 8'h00);
      end_of_service_cmd(1'h1);
      end_of_service_cmd(1'h0);
    end
    apb(1'h1, OFF_CMD, 32'h0000_0035);
    apb(1'h0, OFF_STAT_M, 32'h0000_0000);
    `CHK("lowest", 32'h0005_0000, r)
    src(8'h06, 8'h00);
    ack(v);
    `CHK("rotated", 8'h26, v)
    end_of_service_cmd(1'h0);
    ack(v);
    `CHK("next", 8'h25, v)
    src(8'h00, 8'h00);
    end_of_service_cmd(1'h0);
    apb(1'h1, OFF_CMD, 32'h0000_0037);
    apb(1'h1, OFF_PINCFG, 32'h0000_0100);
    src(8'h21, 8'h00);
    repeat (8) @(posedge pclk);
    `CHK("grounded", 1'h0, cpu_request)
    src(8'h21, 8'h20);
    ack(v);
    `CHK("shared", 8'h41, v)
    src(8'h00, 8'h00);
    end_of_service_cmd(1'h1);
    end_of_service_cmd(1'h0);
    ack(v);
    `CHK("spurious", 8'h27, v)
    apb(1'h1, OFF_CFG_M, 32'h0000_0c20);
    src(8'h00, 8'h01);
    ack(v);
    apb(1'h0, OFF_STAT_M, 32'h0000_0000);
    `CHK("auto end", 32'h0000_0000, r)
    src(8'h00, 8'h00);
    apb(1'h1, OFF_CFG_M, 32'h0000_0120);
    src(8'h00, 8'h01);
    ack(v);
    apb(1'h0, OFF_STAT_M, 32'h0000_0000);
    `CHK("level", 32'h0000_0101, r)
    apb(1'h1, OFF_CMD, 32'h0000_0020);
    ack(v);
    `CHK("level again", 8'h20, v)
    src(8'h00, 8'h00);
    apb(1'h1, OFF_CMD, 32'h0000_0020);
    apb(1'h0, OFF_STAT_M, 32'h0000_0000);
    `CHK("specific end", 32'h0000_0000, r)
    apb(1'h1, OFF_CFG_M, 32'h0000_1020);
    src(8'h00, 8'h10);
    ack(v);
    src(8'h00, 8'h18);
    ack(v);
    `CHK("special mask", 8'h24, v)
    src(8'h00, 8'h00);
    end_of_service_cmd(1'h0);
    end_of_service_cmd(1'h0);
    apb(1'h1, OFF_CFG_M, 32'h0000_0020);
    apb(1'h1, OFF_CASC, 32'h0000_0002);
    apb(1'h1, OFF_PINCFG, 32'h0000_0101);
    src(8'h01, 8'h00);
    ack(v);
    `CHK("ext slave", 3'h1, cascade_select)
    finish_test;
  end
endmodule

bind interrupt_unit interrupt_unit_asserts interrupt_unit_asserts_i (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .acknowledge_strobe_n,
  .cpu_request, .vector_out, .vector_valid, .cascade_select, .cascade_addr_out,
  .cascade_addr_en
);
